// file: hdl/smp_pkg.sv
package smp_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam int RATE_W = 2;
  localparam int HALF_W = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;

  // ----------------------------------------------------------------
  // Master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TRAIL = 2'b11
  } smp_state_e;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  // Last count of a half period: 1, 2, 4 or 8 system clocks
  function automatic logic [HALF_W-1:0] half_last(input logic [RATE_W-1:0] sel);
    case (sel)
      2'h0: half_last = 4'h0;
      2'h1: half_last = 4'h1;
      2'h2: half_last = 4'h3;
      default: half_last = 4'h7;
    endcase
  endfunction

  // Shift one bit in at the end chosen by the bit order
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsbf);
    shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // Bit that leaves the shifter next
  function automatic logic out_bit(input logic [7:0] sh, input logic lsbf);
    out_bit = lsbf ? sh[0] : sh[7];
  endfunction

endpackage

// file: hdl/smp_port.sv
`timescale 1ns/10ps
// Behaviour
// - Master or slave; clock at most half system.
// - Flags for transfer complete and write collision.
// - Mode fault flags a contending master.
// - Received byte moves to separate read buffer.
// - Eight bits shift on master-out, master-in lines.
// - Shift clock driven as master, input as slave.
// - Exactly eight shift clocks exchange one byte.
// - Slave active only while select held low.
// - Select pin unused as master unless fault detection or automatic select.
// - Automatic select toggles between consecutive bytes.
// - Master sends from one shifter and receives into a separate one.
// - Most significant first; low bit first optional.
// - Status and data storage provided; control taken straight from input ports.
module smp_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic master_en,
  input wire logic low_bit_first_enable,
  input wire logic [smp_pkg::RATE_W-1:0] rate_sel,
  input wire logic fault_det_en,
  input wire logic auto_select_en,
  input wire logic tx_wr,
  input wire logic [smp_pkg::BYTE_W-1:0] tx_data,
  output logic [smp_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic busy,
  output logic xfer_done_flag,
  output logic write_coll_flag,
  output logic mode_fault_flag,
  output logic overrun_flag,
  input wire logic clr_xfer_done,
  input wire logic clr_write_coll,
  input wire logic clr_mode_fault,
  input wire logic clr_overrun,
  input wire logic shift_clock_link,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n
);
  import smp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] miso_sync_q;
  logic [1:0] ss_sync_q;
  logic [2:0] tgl_sync_q;
  logic miso_s;
  logic ss_s;
  logic master_act;
  logic slave_sel;
  logic fault;
  logic coll;
  logic start;
  logic half_done;
  logic m_done;
  logic s_done;
  logic push_v;
  logic [7:0] push_d;
  logic full;
  logic pop;
  smp_state_e st_q;
  logic [HALF_W-1:0] half_q;
  logic [2:0] bit_q;
  logic sck_q;
  logic rise_ev;
  logic [1:0] rise_dly_q;
  logic [2:0] mcnt_q;
  logic [7:0] mrx_q;
  logic [7:0] msh_q;
  logic [7:0] tx_hold_q;
  logic [7:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic modf_q;
  logic [2:0] scnt_q;
  logic [7:0] ssh_q;
  logic [7:0] srx_q;
  logic stgl_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Idle select reads high so reset does not fake a selection
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      miso_sync_q <= 2'h0;
      ss_sync_q <= 2'h3;
    end else if (ce) begin
      miso_sync_q <= {miso_sync_q[0], miso_i};
      ss_sync_q <= {ss_sync_q[0], ss_n_i};
    end
  end

  assign miso_s = miso_sync_q[1];
  assign ss_s = ss_sync_q[1];

  // ----------------------------------------------------------------
  // Mode and request decode
  // ----------------------------------------------------------------
  // fault drops master
  assign master_act = master_en & ~modf_q;
  assign slave_sel = ~master_act & ~ss_s;
  // contention detect; auto select drives the pin itself
  assign fault = master_act & fault_det_en & ~auto_select_en & ~ss_s;
  assign full = (cnt_q == BUF_FULL);
  // A full read buffer stalls new master bytes
  assign busy = (st_q != ST_IDLE) | slave_sel | (master_act & full);
  assign coll = tx_wr & busy;
  assign start = tx_wr & ~busy & master_act & ~fault;
  assign half_done = (half_q == half_last(rate_sel));
  assign rise_ev = (st_q == ST_SHIFT) & half_done & ~sck_q;

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  // half periods of 1 to 8 clocks, so never above half rate
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      half_q <= '0;
      bit_q <= FIRST_BIT;
      sck_q <= 1'b0;
      msh_q <= DATA_RST;
    end else if (ce) begin
      if (fault) begin
        st_q <= ST_IDLE;
        sck_q <= 1'b0;
        half_q <= '0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (start) begin
              msh_q <= tx_data;
              st_q <= ST_LEAD;
              half_q <= '0;
              bit_q <= FIRST_BIT;
            end
          end
          ST_LEAD: begin
            half_q <= half_done ? '0 : half_q + 4'h1;
            if (half_done) begin
              st_q <= ST_SHIFT;
            end
          end
          // eight clock cycles, byte swap through both shifters
          ST_SHIFT: begin
            half_q <= half_done ? '0 : half_q + 4'h1;
            if (half_done) begin
              sck_q <= ~sck_q;
              if (sck_q) begin
                msh_q <= shift_in(msh_q, 1'b0, low_bit_first_enable);
                if (bit_q == LAST_BIT) begin
                  st_q <= ST_TRAIL;
                end else begin
                  bit_q <= bit_q + 3'h1;
                end
              end
            end
          end
          ST_TRAIL: begin
            half_q <= half_done ? '0 : half_q + 4'h1;
            if (half_done) begin
              st_q <= ST_IDLE;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Master receive path
  // ----------------------------------------------------------------
  // far byte taken two clocks after each rise, the synchroniser
  // lag, so the bit is still the one that stood on the pin at the rise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rise_dly_q <= 2'h0;
      mcnt_q <= FIRST_BIT;
      mrx_q <= DATA_RST;
    end else if (ce) begin
      rise_dly_q <= fault ? 2'h0 : {rise_dly_q[0], rise_ev};
      if (start) begin
        mcnt_q <= FIRST_BIT;
      end else if (rise_dly_q[1]) begin
        mrx_q <= shift_in(mrx_q, miso_s, low_bit_first_enable);
        mcnt_q <= mcnt_q + 3'h1;
      end
    end
  end

  // Eighth delayed sample ends the byte; an abort empties the pipe
  assign m_done = rise_dly_q[1] & (mcnt_q == LAST_BIT) & ~fault;

  // ----------------------------------------------------------------
  // Slave transmit holding word
  // ----------------------------------------------------------------
  // Held still while selected, so the link side may read it directly
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_hold_q <= DATA_RST;
    end else if (ce && tx_wr && !busy && !master_act) begin
      tx_hold_q <= tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Slave shifter on the link clock
  // ----------------------------------------------------------------
  // a high select clears the bit count at once
  always_ff @(posedge shift_clock_link or posedge ss_n_i) begin
    if (ss_n_i) begin
      scnt_q <= FIRST_BIT;
    end else begin
      scnt_q <= scnt_q + 3'h1;
    end
  end

  // order chosen by the bit-order control, data register unchanged
  always_ff @(posedge shift_clock_link) begin
    ssh_q <= shift_in((scnt_q == FIRST_BIT) ? tx_hold_q : ssh_q, mosi_i,
                      low_bit_first_enable);
  end

  // Completed byte and a toggle that announces it
  always_ff @(posedge shift_clock_link or posedge sys_rst) begin
    if (sys_rst) begin
      stgl_q <= 1'b0;
      srx_q <= DATA_RST;
    end else if (scnt_q == LAST_BIT) begin
      stgl_q <= ~stgl_q;
      srx_q <= shift_in(ssh_q, mosi_i, low_bit_first_enable);
    end
  end

  // Toggle crossing; the word stays put for eight link clocks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tgl_sync_q <= 3'h0;
    end else if (ce) begin
      tgl_sync_q <= {tgl_sync_q[1:0], stgl_q};
    end
  end

  assign s_done = tgl_sync_q[2] ^ tgl_sync_q[1];

  // ----------------------------------------------------------------
  // Two-entry read buffer
  // ----------------------------------------------------------------
  // received bytes leave the shifter at once
  assign push_v = m_done | s_done;
  assign push_d = m_done ? shift_in(mrx_q, miso_s, low_bit_first_enable) : srx_q;
  assign pop = rx_valid & rx_ready;
  assign rx_valid = (cnt_q != BUF_EMPTY);
  assign rx_data = mem_q[rp_q];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= BUF_EMPTY;
      mem_q[0] <= DATA_RST;
      mem_q[1] <= DATA_RST;
    end else if (ce) begin
      if (push_v && !full) begin
        mem_q[wp_q] <= push_d;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push_v & ~full} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------------------------------
  // status as plain ports
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xfer_done_flag <= 1'b0;
      write_coll_flag <= 1'b0;
      modf_q <= 1'b0;
      overrun_flag <= 1'b0;
    end else if (ce) begin
      xfer_done_flag <= push_v | (xfer_done_flag & ~clr_xfer_done);
      write_coll_flag <= coll | (write_coll_flag & ~clr_write_coll);
      modf_q <= fault | (modf_q & ~clr_mode_fault);
      overrun_flag <= (s_done & full) | (overrun_flag & ~clr_overrun);
    end
  end

  assign mode_fault_flag = modf_q;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // data and clock directions follow the mode
  assign shift_clock_pin_o = sck_q;
  assign shift_clock_pin_oe_n = ~master_act;
  assign mosi_o = out_bit(msh_q, low_bit_first_enable);
  assign mosi_oe_n = ~master_act;
  assign miso_o = out_bit((scnt_q == FIRST_BIT) ? tx_hold_q : ssh_q, low_bit_first_enable);
  assign miso_oe_n = ~slave_sel;
  // select low only around each byte and driven high between; left free without automatic select
  assign ss_n_o = ~(auto_select_en & (st_q != ST_IDLE));
  assign ss_n_oe_n = ~(master_act & auto_select_en);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] rise_q;

  always_ff @(posedge clock) begin
    if (sys_rst || st_q == ST_LEAD) begin
      rise_q <= 4'h0;
    end else if (ce && st_q == ST_SHIFT && half_done && !sck_q) begin
      rise_q <= rise_q + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_pin_dir;
    master_act |-> !mosi_oe_n && miso_oe_n;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("data pin direction wrong");

  property p_clk_dir;
    master_act != shift_clock_pin_oe_n;
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong");

  property p_rate;
    $rose(sck_q) && rate_sel != 2'h0 |=> sck_q || st_q == ST_IDLE;
  endproperty
  a_rate: assert property (p_rate) else $error("shift clock too fast");

  property p_eight;
    st_q == ST_TRAIL && $past(st_q) == ST_SHIFT |-> rise_q == BITS_PER_BYTE;
  endproperty
  a_eight: assert property (p_eight) else $error("byte not eight clocks");

  property p_done;
    ce && m_done |=> xfer_done_flag && rx_valid;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_buf;
    ce && push_v && !full && !pop |=> cnt_q == $past(cnt_q) + 2'h1;
  endproperty
  a_buf: assert property (p_buf) else $error("byte not buffered");

  property p_wcol;
    ce && tx_wr && busy && !(st_q == ST_SHIFT && half_done && sck_q)
      |=> write_coll_flag && $stable(msh_q);
  endproperty
  a_wcol: assert property (p_wcol) else $error("collision not flagged");

  property p_modf;
    ce && fault |=> mode_fault_flag && st_q == ST_IDLE && !master_act;
  endproperty
  a_modf: assert property (p_modf) else $error("mode fault not handled");

  property p_slave_off;
    $past(ce) && $past(ce, 2) && $past(ss_n_i, 2) && !master_act |-> miso_oe_n;
  endproperty
  a_slave_off: assert property (p_slave_off) else $error("unselected slave drives");

  property p_ss_free;
    master_act && !auto_select_en |-> ss_n_oe_n;
  endproperty
  a_ss_free: assert property (p_ss_free) else $error("select pin driven");

  property p_order;
    ce && start |=> mosi_o == (low_bit_first_enable ? $past(tx_data[0]) : $past(tx_data[7]));
  endproperty
  a_order: assert property (p_order) else $error("bit order wrong");

  c_master: cover property (ce && m_done);
  c_slave: cover property (ce && s_done);
  c_fault: cover property (ce && fault);

endmodule

// file: bench/smp_far_slave.sv
`timescale 1ns/10ps
// ----------------------------------------
// Far slave answering master traffic
// ----------------------------------------
module smp_far_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic lsbf,
  input wire logic [7:0] preset,
  output logic miso,
  output logic [7:0] got,
  output int rises
);
  logic [7:0] sh;
  logic bit_q;
  // Known state before the first select
  initial begin
    miso = 1'b0;
    got = 8'h00;
    rises = 0;
  end
  always @(negedge sel_n) begin
    sh = preset;
    rises = 0;
    miso = lsbf ? sh[0] : sh[7];
  end
  always @(posedge sck) begin
    bit_q = mosi;
    rises = rises + 1;
  end
  // shift on fall, next bit out
  always @(negedge sck) begin
    sh = lsbf ? {bit_q, sh[7:1]} : {sh[6:0], bit_q};
    got = sh;
    miso = lsbf ? sh[0] : sh[7];
  end
  // released line flips, so stale data cannot pass for a match
  always @(posedge sel_n) miso = ~miso;
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// Self-checking bench for the serial port
// ----------------------------------------
module tb_top;
  import smp_pkg::*;
  logic clock, sys_rst, ce, master_en, low_bit_first_enable, fault_det_en, auto_select_en;
  logic [RATE_W-1:0] rate_sel;
  logic tx_wr, rx_ready, clr_xfer_done, clr_write_coll, clr_mode_fault, clr_overrun;
  logic [BYTE_W-1:0] tx_data, rx_data, preset, got, b, m;
  logic rx_valid, busy, xfer_done_flag, write_coll_flag, mode_fault_flag, overrun_flag;
  logic shift_clock_link, shift_clock_pin_o, shift_clock_pin_oe_n;
  logic mosi_i, mosi_o, mosi_oe_n, miso_i, miso_o, miso_oe_n, ss_n_i, ss_n_o, ss_n_oe_n;
  int rises, err_count, compares, seed, n;
  logic [7:0] exp_q[$];

  smp_port dut (.clock, .sys_rst, .ce, .master_en, .low_bit_first_enable, .rate_sel,
    .fault_det_en, .auto_select_en, .tx_wr, .tx_data, .rx_data, .rx_valid, .rx_ready, .busy,
    .xfer_done_flag, .write_coll_flag, .mode_fault_flag, .overrun_flag, .clr_xfer_done,
    .clr_write_coll, .clr_mode_fault, .clr_overrun, .shift_clock_link, .shift_clock_pin_o,
    .shift_clock_pin_oe_n, .mosi_i, .mosi_o, .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n,
    .ss_n_i, .ss_n_o, .ss_n_oe_n);

  smp_far_slave far (.sck(shift_clock_pin_o), .mosi(mosi_o), .sel_n(ss_n_o),
    .lsbf(low_bit_first_enable), .preset(preset), .miso(miso_i), .got(got), .rises(rises));

  // System clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle strobe: 0 write, 1 pop, 2..5 flag clears; one quiet cycle after
  task automatic pulse(input int k);
    {clr_overrun, clr_mode_fault, clr_write_coll, clr_xfer_done, rx_ready, tx_wr} = 6'(1 << k);
    @(negedge clock);
    {clr_overrun, clr_mode_fault, clr_write_coll, clr_xfer_done, rx_ready, tx_wr} = 6'h00;
    @(negedge clock);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = xfer_done_flag;
      1: sig = rx_valid;
      2: sig = mode_fault_flag;
      default: sig = ss_n_o;
    endcase
  endfunction

  // Bounded wait; a hang ends the run
  task automatic waitfor(input int k);
    n = 0;
    while (sig(k) !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        err_count++;
        $display("[FAIL] %0t wait timed out", $time);
        tally_and_finish();
      end
    end
  endtask

  // Master byte; the far slave answers with a random byte
  task automatic mxfer(input logic [7:0] d, input bit coll);
    int h;
    int off;
    h = 1 << rate_sel;
    off = 1;
    preset = 8'($urandom);
    tx_data = d;
    pulse(0);
    if (coll) begin
      repeat (4) @(negedge clock);
      tx_data = ~d;
      pulse(0);
      check(write_coll_flag, 8'h01, "collision flag");
      pulse(3);
      off = 9;
    end
    waitfor(0);
    check(n + off >= 16 * h && n + off <= 16 * h + 4, 8'h01, "shift rate");
    waitfor(3);
    check(got, d, "byte at far end");
    check(8'(rises), 8'h08, "clock count");
    check({shift_clock_pin_oe_n, mosi_oe_n, ss_n_oe_n}, 8'h00, "master pins");
    exp_q.push_back(preset);
    pulse(2);
    check(xfer_done_flag, 8'h00, "done clear");
  endtask

  task automatic pop();
    waitfor(1);
    check(rx_data, exp_q.pop_front(), "read buffer");
    pulse(1);
  endtask

  // Link master: 32 ns period, only inside frames
  task automatic sbyte(input logic [7:0] d, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      mosi_i = d[i];
      #16;
      m[i] = miso_o;
      shift_clock_link = 1'b1;
      #16;
      shift_clock_link = 1'b0;
    end
    mosi_i = ~mosi_i;
  endtask

  initial begin
    {tx_wr, rx_ready, clr_xfer_done, clr_write_coll, clr_mode_fault, clr_overrun} = 6'h00;
    {shift_clock_link, mosi_i, fault_det_en, low_bit_first_enable} = 4'h0;
    {ce, sys_rst, master_en, auto_select_en, ss_n_i} = 5'h1F;
    rate_sel = 2'h2;
    tx_data = 8'h00;
    preset = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    seed = $urandom(2172);
    repeat (3) @(negedge clock);
    check({xfer_done_flag, write_coll_flag, mode_fault_flag, overrun_flag, rx_valid,
      shift_clock_pin_o, ss_n_o}, 8'h01, "reset state");
    $display("test reset done");
    // one master and one selected slave at a time
    for (int r = 0; r < 4; r++) begin
      for (int l = 0; l < 2; l++) begin
        rate_sel = 2'(r);
        low_bit_first_enable = l[0];
        mxfer(8'($urandom), 1'b0);
        pop();
      end
    end
    low_bit_first_enable = 1'b0;
    mxfer(8'hA5, 1'b1);
    pop();
    $display("test master done");
    mxfer(8'($urandom), 1'b0);
    mxfer(8'($urandom), 1'b0);
    check(busy, 8'h01, "busy when full");
    pulse(0);
    check(write_coll_flag, 8'h01, "write while full");
    pulse(3);
    pop();
    pop();
    check(rx_valid, 8'h00, "buffer empty");
    $display("test buffer done");
    auto_select_en = 1'b0;
    fault_det_en = 1'b1;
    ss_n_i = 1'b0;
    waitfor(2);
    @(negedge clock);
    check({shift_clock_pin_oe_n, mosi_oe_n}, 8'h03, "left master");
    ss_n_i = 1'b1;
    fault_det_en = 1'b0;
    pulse(4);
    check(mode_fault_flag, 8'h00, "fault clear");
    $display("test fault done");
    master_en = 1'b0;
    tx_data = 8'h96;
    pulse(0);
    ss_n_i = 1'b0;
    repeat (4) @(negedge clock);
    check({mosi_oe_n, shift_clock_pin_oe_n, miso_oe_n}, 8'h06, "slave pins");
    #3;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      sbyte(b, 8);
      if (i == 0) check(m, 8'h96, "slave out byte");
      if (i < 2) exp_q.push_back(b);
    end
    sbyte(8'hFF, 4);
    @(negedge clock);
    ss_n_i = 1'b1;
    pop();
    pop();
    check(overrun_flag, 8'h01, "byte lost when full");
    check(rx_valid, 8'h00, "partial dropped");
    pulse(5);
    ss_n_i = 1'b0;
    repeat (4) @(negedge clock);
    #3;
    b = 8'($urandom);
    sbyte(b, 8);
    exp_q.push_back(b);
    @(negedge clock);
    ss_n_i = 1'b1;
    pop();
    $display("test slave done");
    tally_and_finish();
  end
endmodule
